// [verilog/rpg_map.svh]
// Register offsets, field positions, reset values and timing for the record path
`ifndef RPG_MAP_SVH
`define RPG_MAP_SVH

`define RPG_MIC_CTRL_OFS     8'h00
`define RPG_INAMP_CTRL_OFS   8'h04
`define RPG_ADC_CTRL_OFS     8'h08
`define RPG_ADC_GAIN_OFS     8'h0C
`define RPG_GAIN_STATUS_OFS  8'h10
`define RPG_HPF_CTRL_OFS     8'h14

`define RPG_MIC_MODE_LSB     0
`define RPG_MIC_EN_BIT       3
`define RPG_MIC_MUTE_BIT     4
`define RPG_MIC_GAIN_LSB     5
`define RPG_IA_GAIN_LSB      0
`define RPG_IA_EN_BIT        4
`define RPG_IA_MUTE_BIT      5
`define RPG_IA_ZC_BIT        6
`define RPG_IA_RAMP_BIT      7
`define RPG_ADC_EN_BIT       0
`define RPG_ADC_MUTE_BIT     1
`define RPG_ADC_RAMP_BIT     2
`define RPG_ADC_RATE_LSB     3
`define RPG_ADC_SR_LSB       8
`define RPG_ST_IA_LSB        8
`define RPG_ST_PEND_BIT      12
`define RPG_HPF_EN_BIT       0
`define RPG_HPF_AUDIO_LSB    1
`define RPG_HPF_VOICE_BIT    3
`define RPG_HPF_VCORNER_LSB  4

`define RPG_MIC_CTRL_RST     16'h0020
`define RPG_INAMP_CTRL_RST   16'h0003
`define RPG_ADC_CTRL_RST     16'h0B00
`define RPG_ADC_GAIN_RST     16'h006F
`define RPG_HPF_CTRL_RST     16'h0001

`define RPG_DGAIN_ZERO_DB    7'h6F
`define RPG_IA_GAIN_ZERO_DB  4'h3

`define RPG_ZC_TIMEOUT_MS    100
`define RPG_CLK_MHZ          250

`endif

// [verilog/rpg_pkg.sv]
// Types shared by the record path control block
package rpg_pkg;
  typedef enum logic [2:0] {
    RPG_MIC_HEADSET     = 3'h0,
    RPG_MIC_FULL_DIFF   = 3'h1,
    RPG_MIC_PSEUDO_DIFF = 3'h2,
    RPG_MIC_SE_POS      = 3'h3,
    RPG_MIC_SE_NEG      = 3'h4
  } rpg_mic_mode_e;

  typedef enum logic [2:0] {
    RPG_IA_IDLE = 3'b001,
    RPG_IA_WAIT = 3'b010,
    RPG_IA_RAMP = 3'b100
  } rpg_ia_state_e;

  typedef logic [23:0] rpg_sample_t;
endpackage

// [verilog/rpg_record_path.sv]
// Mono record path control: mic and input amp, ADC gain, high-pass filter
// Function
// R01: Preamp offers headset, differential, pseudo, single-ended modes
// R02: Preamp enable bit powers it; mute silences
// R03: Preamp gain code -6 to +36 dB
// R04: Input amplifier on only when enable written one
// R05: Input amp gain -4.5 to +18 dB, 1.5 dB
// R06: Zero-cross update waits, forced after 100 ms
// R07: Ramp walks every code; overrides zero-cross
// R08: Input amplifier silent while its mute set
// R09: Modulator clock picked by sample-rate family
// R10: 24-bit samples at programmed 8 to 96 kHz
// R11: ADC converts only while enabled
// R12: Digital gain -83.25 to +12 dB, 0.75 dB
// R13: Active digital gain readable in status register
// R14: ADC mute; digital gain ramps at chosen rate
// R15: DC high-pass on after reset, bypassable
// R16: Audio corner code doubles corner per step
// R17: Voice mode needs voice and filter enable
// R18: Corner scales with the sample rate
// R19: Plain gain write applies on next sample
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`include "rpg_map.svh"

module rpg_record_path #(
  parameter int unsigned ZC_TIMEOUT_CYCLES = `RPG_ZC_TIMEOUT_MS * `RPG_CLK_MHZ * 1000
) (
  input  wire logic                   CLK_SYS,
  input  wire logic                   RESET,
  input  wire logic                   CYC_I,
  input  wire logic                   STB_I,
  input  wire logic                   WE_I,
  input  wire logic [7:0]             ADR_I,
  input  wire logic [3:0]             SEL_I,
  input  wire logic [31:0]            DAT_I,
  output logic      [31:0]            DAT_O,
  output logic                        ACK_O,
  input  wire rpg_pkg::rpg_sample_t   ADC_DATA,
  input  wire logic                   ADC_VALID,
  output rpg_pkg::rpg_sample_t        OUT_DATA,
  output logic                        OUT_VALID,
  output rpg_pkg::rpg_mic_mode_e      MIC_MODE,
  output logic                        MIC_AMP_EN,
  output logic                        MIC_AMP_MUTE,
  output logic      [2:0]             MIC_GAIN,
  output logic                        IN_AMP_EN,
  output logic                        IN_AMP_MUTE,
  output logic      [3:0]             IN_AMP_GAIN,
  output logic                        ADC_EN,
  output logic      [3:0]             ADC_RATE,
  output logic                        MOD_CLK_44K1
);
  import rpg_pkg::*;

  localparam int ZC_CNT_W = $clog2(ZC_TIMEOUT_CYCLES + 1);

  logic [15:0]         mic_q, ia_q, adc_q, dgain_q, hpf_q;
  logic                ack_q;
  logic [31:0]         rdata_q;
  logic [15:0]         rd_d;
  logic                wb_req, wr_en;
  logic [3:0]          ia_cur_q;
  rpg_ia_state_e       ia_st_q;
  logic [ZC_CNT_W-1:0] zc_cnt_q;
  logic                prev_sign_q;
  logic [6:0]          dg_cur_q;
  logic [2:0]          dg_div_q;
  rpg_sample_t         g_data_q;
  logic                g_valid_q;
  logic signed [25:0]  x_prev_q, y_prev_q;
  rpg_sample_t         out_q;
  logic                out_valid_q;

  // Field views
  logic [3:0] ia_tgt;
  logic       ia_zc_on, ia_ramp_on, adc_en, adc_mute, adc_ramp, hpf_en, voice_on;
  logic [1:0] ramp_rate, audio_corner;
  logic [2:0] voice_corner;
  logic [6:0] dg_tgt;
  logic       smp, zero_cross;
  logic [15:0] mic_m, ia_m;

  assign ia_tgt       = ia_q[`RPG_IA_GAIN_LSB +: 4];
  assign ia_zc_on     = ia_q[`RPG_IA_ZC_BIT];
  assign ia_ramp_on   = ia_q[`RPG_IA_RAMP_BIT];
  assign adc_en       = adc_q[`RPG_ADC_EN_BIT];
  assign adc_mute     = adc_q[`RPG_ADC_MUTE_BIT];
  assign adc_ramp     = adc_q[`RPG_ADC_RAMP_BIT];
  assign ramp_rate    = adc_q[`RPG_ADC_RATE_LSB +: 2];
  assign dg_tgt       = dgain_q[6:0];
  assign hpf_en       = hpf_q[`RPG_HPF_EN_BIT];
  assign audio_corner = hpf_q[`RPG_HPF_AUDIO_LSB +: 2];
  assign voice_on     = hpf_q[`RPG_HPF_VOICE_BIT] & hpf_en; // R17
  assign voice_corner = hpf_q[`RPG_HPF_VCORNER_LSB +: 3];
  assign mic_m        = merge(mic_q, DAT_I, SEL_I);
  assign ia_m         = merge(ia_q, DAT_I, SEL_I);

  // Byte-lane merge shared by every writable register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Fractional part of a 0.75 dB step, Q15 over 2^(k/8)
  function automatic logic [16:0] step_mant(input logic [2:0] k);
    case (k)
      3'h0:    step_mant = 17'h08000;
      3'h1:    step_mant = 17'h08B96;
      3'h2:    step_mant = 17'h09838;
      3'h3:    step_mant = 17'h0A5FF;
      3'h4:    step_mant = 17'h0B505;
      3'h5:    step_mant = 17'h0C567;
      3'h6:    step_mant = 17'h0D745;
      default: step_mant = 17'h0EAC1;
    endcase
  endfunction

  // Feedback coefficient, 2*pi*fc/fs in Q16; fixed fraction of fs so corners track rate
  function automatic logic [16:0] hpf_coef(input logic voice, input logic [1:0] ac,
                                           input logic [2:0] vc);
    if (!voice) begin
      case (ac) // R16
        2'h0:    hpf_coef = 17'h00011;
        2'h1:    hpf_coef = 17'h00022;
        2'h2:    hpf_coef = 17'h00045;
        default: hpf_coef = 17'h00089;
      endcase
    end else begin
      case (vc) // R17
        3'h0:    hpf_coef = 17'h00080;
        3'h1:    hpf_coef = 17'h00506;
        3'h2:    hpf_coef = 17'h00A0D;
        3'h3:    hpf_coef = 17'h0141B;
        3'h4:    hpf_coef = 17'h01E28;
        3'h5:    hpf_coef = 17'h02836;
        3'h6:    hpf_coef = 17'h03C51;
        default: hpf_coef = 17'h0506C;
      endcase
    end
  endfunction

  function automatic rpg_sample_t sat24(input logic signed [40:0] v);
    if (v > 41'sh000007FFFFF) sat24 = 24'h7FFFFF;
    else if (v < -41'sh00000800000) sat24 = 24'h800000;
    else sat24 = v[23:0];
  endfunction

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_req = CYC_I & STB_I;
  assign wr_en  = wb_req & WE_I & ~ack_q;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req & ~ack_q;
    end
  end

  always_comb begin
    rd_d = 16'h0000;
    case (ADR_I)
      `RPG_MIC_CTRL_OFS:    rd_d = mic_q;
      `RPG_INAMP_CTRL_OFS:  rd_d = ia_q;
      `RPG_ADC_CTRL_OFS:    rd_d = adc_q;
      `RPG_ADC_GAIN_OFS:    rd_d = dgain_q;
      `RPG_GAIN_STATUS_OFS: begin
        rd_d[6:0]                   = dg_cur_q; // R13
        rd_d[`RPG_ST_IA_LSB +: 4]   = ia_cur_q;
        rd_d[`RPG_ST_PEND_BIT]      = (ia_st_q != RPG_IA_IDLE) || (ia_cur_q != ia_tgt);
      end
      `RPG_HPF_CTRL_OFS:    rd_d = hpf_q;
      default:              rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rdata_q <= 32'h00000000;
    end else if (wb_req & ~ack_q) begin
      rdata_q <= {16'h0000, rd_d};
    end
  end

  // Control registers; unmapped writes are dropped
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      mic_q   <= `RPG_MIC_CTRL_RST;
      ia_q    <= `RPG_INAMP_CTRL_RST;
      adc_q   <= `RPG_ADC_CTRL_RST;
      dgain_q <= `RPG_ADC_GAIN_RST;
      hpf_q   <= `RPG_HPF_CTRL_RST; // R15
    end else if (wr_en) begin
      case (ADR_I)
        `RPG_MIC_CTRL_OFS: begin
          // Undefined mode codes keep the previous mode; enable, mute and gain still update
          mic_q <= (mic_m[2:0] > 3'h4) ? {8'h00, mic_m[7:3], mic_q[2:0]} // R01
                                        : {8'h00, mic_m[7:0]};
        end
        `RPG_INAMP_CTRL_OFS: ia_q    <= {8'h00, ia_m[7:0]};
        `RPG_ADC_CTRL_OFS:   adc_q   <= merge(adc_q, DAT_I, SEL_I) & 16'h0F1F;
        `RPG_ADC_GAIN_OFS:   dgain_q <= merge(dgain_q, DAT_I, SEL_I) & 16'h007F;
        `RPG_HPF_CTRL_OFS:   hpf_q   <= merge(hpf_q, DAT_I, SEL_I) & 16'h007F;
        default: ;
      endcase
    end
  end

  // Analog front-end controls
  assign MIC_MODE     = rpg_mic_mode_e'(mic_q[`RPG_MIC_MODE_LSB +: 3]); // R01
  assign MIC_AMP_EN   = mic_q[`RPG_MIC_EN_BIT]; // R02
  assign MIC_AMP_MUTE = mic_q[`RPG_MIC_MUTE_BIT]; // R02
  assign MIC_GAIN     = mic_q[`RPG_MIC_GAIN_LSB +: 3]; // R03
  assign IN_AMP_EN    = ia_q[`RPG_IA_EN_BIT]; // R04
  assign IN_AMP_MUTE  = ia_q[`RPG_IA_MUTE_BIT]; // R08
  assign IN_AMP_GAIN  = ia_cur_q; // R05
  assign ADC_EN       = adc_en; // R11
  assign ADC_RATE     = adc_q[`RPG_ADC_SR_LSB +: 4]; // R10
  // 44.1 kHz family codes share 2'b10 in the low bits
  assign MOD_CLK_44K1 = (adc_q[`RPG_ADC_SR_LSB +: 2] == 2'h2); // R09

  // Sample strobe and zero crossing on the raw converter stream
  assign smp        = ADC_VALID & adc_en; // R11
  assign zero_cross = smp & (ADC_DATA[23] != prev_sign_q);

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      prev_sign_q <= 1'b0;
    end else if (smp) begin
      prev_sign_q <= ADC_DATA[23];
    end
  end

  // Input amplifier gain update sequencer
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ia_st_q  <= RPG_IA_IDLE;
      ia_cur_q <= `RPG_IA_GAIN_ZERO_DB;
      zc_cnt_q <= '0;
    end else begin
      unique case (ia_st_q)
        RPG_IA_IDLE: begin
          zc_cnt_q <= '0;
          if (ia_cur_q != ia_tgt) begin
            if (ia_ramp_on) begin
              ia_st_q <= RPG_IA_RAMP; // R07
            end else if (ia_zc_on) begin
              ia_st_q <= RPG_IA_WAIT; // R06
            end else if (smp) begin
              ia_cur_q <= ia_tgt; // R19
            end
          end
        end
        RPG_IA_WAIT: begin
          zc_cnt_q <= zc_cnt_q + 1'b1;
          if (ia_ramp_on) begin
            ia_st_q <= RPG_IA_RAMP; // R07
          end else if (ia_cur_q == ia_tgt || !ia_zc_on) begin
            ia_st_q <= RPG_IA_IDLE;
          end else if (zero_cross || zc_cnt_q >= ZC_CNT_W'(ZC_TIMEOUT_CYCLES - 1)) begin
            ia_cur_q <= ia_tgt; // R06
            ia_st_q  <= RPG_IA_IDLE;
          end
        end
        RPG_IA_RAMP: begin
          if (ia_cur_q == ia_tgt || !ia_ramp_on) begin
            ia_st_q <= RPG_IA_IDLE;
          end else if (smp) begin
            ia_cur_q <= (ia_tgt > ia_cur_q) ? ia_cur_q + 4'h1 : ia_cur_q - 4'h1; // R07
          end
        end
        default: ia_st_q <= RPG_IA_IDLE;
      endcase
    end
  end

  // Digital gain tracking: 1, 2, 4 or 8 samples per 0.75 dB step
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      dg_cur_q <= `RPG_DGAIN_ZERO_DB;
      dg_div_q <= 3'h0;
    end else if (!adc_ramp) begin
      dg_cur_q <= dg_tgt;
      dg_div_q <= 3'h0;
    end else if (smp && dg_cur_q != dg_tgt) begin
      if (dg_div_q >= 3'((4'h1 << ramp_rate) - 4'h1)) begin
        dg_div_q <= 3'h0;
        dg_cur_q <= (dg_tgt > dg_cur_q) ? dg_cur_q + 7'h01 : dg_cur_q - 7'h01; // R14
      end else begin
        dg_div_q <= dg_div_q + 3'h1;
      end
    end
  end

  // Gain stage: code+1 = 8*octave + step, unity at octave 14
  logic [7:0]         g_e;
  logic [4:0]         g_sh;
  logic signed [40:0] g_prod;

  assign g_e    = {1'b0, dg_cur_q} + 8'h01;
  assign g_sh   = 5'h1D - g_e[7:3];
  assign g_prod = $signed(ADC_DATA) * $signed({1'b0, step_mant(g_e[2:0])});

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      g_data_q  <= 24'h000000;
      g_valid_q <= 1'b0;
    end else begin
      g_valid_q <= smp; // R10
      if (smp) begin
        g_data_q <= adc_mute ? 24'h000000 : sat24(g_prod >>> g_sh); // R12 R14
      end
    end
  end

  // First-order DC blocker: y = x - x1 + y1 - c*y1
  logic signed [25:0] h_x;
  logic signed [42:0] h_fb;
  logic signed [40:0] h_y;

  assign h_x  = 26'($signed(g_data_q));
  assign h_fb = y_prev_q * $signed({1'b0, hpf_coef(voice_on, audio_corner, voice_corner)});
  assign h_y  = 41'(h_x - x_prev_q + y_prev_q) - 41'(h_fb >>> 16); // R18

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      x_prev_q <= 26'sh0000000;
      y_prev_q <= 26'sh0000000;
    end else if (!hpf_en || !adc_en) begin
      // Clearing history avoids a step when the filter is re-enabled
      x_prev_q <= 26'sh0000000;
      y_prev_q <= 26'sh0000000;
    end else if (g_valid_q) begin
      x_prev_q <= h_x;
      y_prev_q <= 26'($signed(sat24(h_y))); // R15
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      out_q       <= 24'h000000;
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= g_valid_q & adc_en; // R11
      if (g_valid_q) begin
        out_q <= hpf_en ? sat24(h_y) : g_data_q; // R15
      end
    end
  end

  assign OUT_DATA  = out_q;
  assign OUT_VALID = out_valid_q;
  assign DAT_O     = rdata_q;
  assign ACK_O     = ack_q;

endmodule

// [verification/rpg_record_path_asserts.sv]
// Port-level checker for the record path control block
`timescale 1ns/100ps
module rpg_record_path_asserts (
  input wire logic                   CLK_SYS,
  input wire logic                   RESET,
  input wire logic                   CYC_I,
  input wire logic                   STB_I,
  input wire logic                   WE_I,
  input wire logic [7:0]             ADR_I,
  input wire logic [31:0]            DAT_O,
  input wire logic                   ACK_O,
  input wire logic                   ADC_VALID,
  input wire logic                   ADC_EN,
  input wire logic                   OUT_VALID,
  input wire rpg_pkg::rpg_mic_mode_e MIC_MODE,
  input wire logic                   MIC_AMP_EN,
  input wire logic                   MIC_AMP_MUTE,
  input wire logic [2:0]             MIC_GAIN,
  input wire logic                   IN_AMP_EN,
  input wire logic                   IN_AMP_MUTE,
  input wire logic [3:0]             ADC_RATE,
  input wire logic                   MOD_CLK_44K1
);
  import rpg_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  property p_ack_take; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not acked");
  property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_rd_hi; ACK_O |-> DAT_O[31:16] == 16'h0000; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_out_lat; (ADC_VALID && ADC_EN) ##1 ADC_EN [*2] |-> OUT_VALID; endproperty
  a_out_lat: assert property (p_out_lat) else $error("sample output missing");
  property p_out_cause; OUT_VALID |-> $past(ADC_VALID && ADC_EN, 2); endproperty
  a_out_cause: assert property (p_out_cause) else $error("output without sample");
  property p_mod_clk; MOD_CLK_44K1 == (ADC_RATE[1:0] == 2'b10); endproperty
  a_mod_clk: assert property (p_mod_clk) else $error("modulator clock family wrong");
  property p_mic_wr;
    $changed({MIC_MODE, MIC_AMP_EN, MIC_AMP_MUTE, MIC_GAIN}) |->
      ACK_O && $past(WE_I) && $past(ADR_I) == 8'h00;
  endproperty
  a_mic_wr: assert property (p_mic_wr) else $error("preamp changed without write");
  property p_ia_wr;
    $changed({IN_AMP_EN, IN_AMP_MUTE}) |-> ACK_O && $past(WE_I) && $past(ADR_I) == 8'h04;
  endproperty
  a_ia_wr: assert property (p_ia_wr) else $error("input amp changed without write");
  property p_adc_wr;
    $changed({ADC_EN, ADC_RATE}) |-> ACK_O && $past(WE_I) && $past(ADR_I) == 8'h08;
  endproperty
  a_adc_wr: assert property (p_adc_wr) else $error("adc control changed without write");
  property p_mode_ok; MIC_MODE <= RPG_MIC_SE_NEG; endproperty
  a_mode_ok: assert property (p_mode_ok) else $error("illegal preamp mode");
endmodule

// [verification/tb_rpg_record_path.sv]
// Self-checking bench for the record path control block
`timescale 1ns/100ps
module tb_rpg_record_path;
  import rpg_pkg::*;
  logic          CLK_SYS = 0, RESET = 1, CYC_I = 0, STB_I = 0, WE_I = 0, ADC_VALID = 0;
  logic [7:0]    ADR_I = 0;
  logic [3:0]    SEL_I = 0, IN_AMP_GAIN, ADC_RATE;
  logic [31:0]   DAT_I = 0, DAT_O;
  logic          ACK_O, OUT_VALID, MIC_AMP_EN, MIC_AMP_MUTE, IN_AMP_EN, IN_AMP_MUTE;
  logic          ADC_EN, MOD_CLK_44K1, ov;
  logic [2:0]    MIC_GAIN;
  rpg_sample_t   ADC_DATA = 0, OUT_DATA, od;
  rpg_mic_mode_e MIC_MODE;
  logic [15:0]   q;
  int            n_errors = 0, checks = 0, cyc = 0;
  rpg_record_path #(.ZC_TIMEOUT_CYCLES(50)) dut (.CLK_SYS, .RESET, .CYC_I, .STB_I, .WE_I,
    .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .ADC_DATA, .ADC_VALID, .OUT_DATA, .OUT_VALID,
    .MIC_MODE, .MIC_AMP_EN, .MIC_AMP_MUTE, .MIC_GAIN, .IN_AMP_EN, .IN_AMP_MUTE,
    .IN_AMP_GAIN, .ADC_EN, .ADC_RATE, .MOD_CLK_44K1);
  always #2 CLK_SYS = ~CLK_SYS;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic fam(input logic [3:0] s);
    return s inside {4'h2, 4'h6, 4'hA, 4'hE};
  endfunction
  function automatic logic [3:0] step(input logic [3:0] c, input logic [3:0] t);
    return (c < t) ? c + 4'h1 : c - 4'h1;
  endfunction
  // Classic single cycle; data taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    CYC_I <= 1;
    STB_I <= 1;
    WE_I <= w;
    ADR_I <= a;
    SEL_I <= 4'h3;
    DAT_I <= {16'h0000, d};
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    if (n == 20) n_errors++;
    q = DAT_O[15:0];
    CYC_I <= 0;
    STB_I <= 0;
  endtask
  // One sample; output looked at two edges after it is taken
  task automatic smp(input rpg_sample_t d);
    @(posedge CLK_SYS);
    ADC_VALID <= 1;
    ADC_DATA <= d;
    @(posedge CLK_SYS);
    ADC_VALID <= 0;
    ADC_DATA <= ~d;
    @(posedge CLK_SYS);
    @(posedge CLK_SYS);
    ov = OUT_VALID;
    od = OUT_DATA;
  endtask
  initial begin
    logic [7:0] ofs [5];
    logic [15:0] rv [5];
    logic [3:0] sr [11];
    logic [15:0] r;
    logic [6:0] dg;
    logic [3:0] g, cur;
    rpg_mic_mode_e em;
    rpg_sample_t d, a;
    ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
    rv = '{16'h0020, 16'h0003, 16'h0B00, 16'h006F, 16'h0001};
    sr = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hE, 4'hF};
    em = RPG_MIC_HEADSET;
    void'($urandom(7));
    repeat (20) @(posedge CLK_SYS);
    RESET <= 0;
    chk("ports", {MIC_GAIN, IN_AMP_GAIN, ADC_RATE}, {3'h1, 4'h3, 4'hB});
    foreach (ofs[i]) begin
      wb(0, ofs[i], 16'h0000);
      chk("reset", q, rv[i]);
    end
    wb(1, 8'h20, 16'hFFFF);
    wb(0, 8'h20, 16'h0000);
    chk("unmapped", q, 0);
    $display("done reset");
    // Codes 5..7 must leave the old mode in place
    for (int m = 0; m < 8; m++) begin
      r = 16'($urandom);
      wb(1, 8'h00, {8'h00, r[7:3], m[2:0]});
      if (m < 5) em = rpg_mic_mode_e'(m[2:0]);
      chk("mic", {MIC_MODE, MIC_AMP_EN, MIC_AMP_MUTE, MIC_GAIN}, {em, r[3], r[4], r[7:5]});
    end
    foreach (sr[i]) begin
      wb(1, 8'h08, {4'h0, sr[i], 8'h01});
      chk("rate", {ADC_EN, ADC_RATE, MOD_CLK_44K1}, {1'b1, sr[i], fam(sr[i])});
    end
    $display("done mic and rate");
    wb(1, 8'h08, 16'h0B00);
    smp(24'($urandom));
    chk("off", ov, 0);
    wb(1, 8'h14, 16'h0000);
    wb(1, 8'h08, 16'h0B01);
    d = 24'($urandom);
    smp(d);
    chk("bypass", {ov, od}, {1'b1, d});
    wb(1, 8'h08, 16'h0B03);
    smp(d);
    chk("adc mute", od, 0);
    dg = 7'($urandom) & 7'h3F;
    wb(1, 8'h08, 16'h0B01);
    wb(1, 8'h0C, {9'h000, dg});
    wb(0, 8'h10, 16'h0000);
    chk("dgain", q[6:0], dg);
    wb(1, 8'h08, 16'h0B05);
    wb(1, 8'h0C, {9'h000, dg + 7'h03});
    smp(d);
    wb(0, 8'h10, 16'h0000);
    chk("dramp", q[6:0], dg + 7'h01);
    smp(d);
    smp(d);
    wb(0, 8'h10, 16'h0000);
    chk("dstatus", q[6:0], dg + 7'h03);
    wb(1, 8'h08, 16'h0B0D);
    wb(1, 8'h0C, {9'h000, dg});
    smp(d);
    wb(0, 8'h10, 16'h0000);
    chk("drate hold", q[6:0], dg + 7'h03);
    smp(d);
    wb(0, 8'h10, 16'h0000);
    chk("drate step", q[6:0], dg + 7'h02);
    $display("done adc");
    r = 16'($urandom);
    g = r[3:0];
    wb(1, 8'h04, {10'h000, r[5], 1'b1, g});
    chk("ia wait", IN_AMP_GAIN, 4'h3);
    chk("ia ctrl", {IN_AMP_EN, IN_AMP_MUTE}, {1'b1, r[5]});
    smp(d);
    chk("ia plain", IN_AMP_GAIN, g);
    cur = g;
    g = g ^ 4'hA;
    wb(1, 8'h04, {8'h00, 2'b11, 2'b01, g});
    for (int k = 0; k < 16 && cur !== g; k++) begin
      smp(24'($urandom));
      cur = step(cur, g);
      chk("ia ramp", IN_AMP_GAIN, cur);
    end
    smp(24'h000100);
    wb(1, 8'h04, {8'h00, 2'b01, 2'b01, ~g});
    smp(24'h000200);
    chk("zc hold", IN_AMP_GAIN, g);
    smp(24'hFFFF00);
    chk("zc cross", IN_AMP_GAIN, 4'(~g));
    wb(1, 8'h04, {8'h00, 2'b01, 2'b01, g});
    repeat (30) @(posedge CLK_SYS);
    chk("zc pending", IN_AMP_GAIN, 4'(~g));
    repeat (30) @(posedge CLK_SYS);
    chk("zc timeout", IN_AMP_GAIN, g);
    $display("done input amp");
    repeat (8) begin
      r = 16'($urandom) & 16'h007F;
      wb(1, 8'h14, r);
      wb(0, 8'h14, 16'h0000);
      chk("hpf", q, r);
    end
    // DC steps: first output passes, second shows the high-pass pull back
    wb(1, 8'h08, 16'h0B01);
    wb(1, 8'h0C, 16'h006F);
    wb(1, 8'h14, 16'h0000);
    wb(1, 8'h14, 16'h0001);
    smp(24'hF00000);
    chk("hpf first", od, 24'hF00000);
    smp(24'hF00000);
    a = od;
    chk("hpf audio", $signed(a) > $signed(24'hF00000) && $signed(a) < 0, 1);
    wb(1, 8'h14, 16'h0000);
    wb(1, 8'h14, 16'h0079);
    smp(24'h100000);
    smp(24'h100000);
    chk("hpf voice", $signed(od) > 0 && $signed(od) < -$signed(a), 1);
    $display("done filter");
    results();
  end
endmodule
bind rpg_record_path rpg_record_path_asserts chk_i (.CLK_SYS, .RESET, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .DAT_O, .ACK_O, .ADC_VALID, .ADC_EN, .OUT_VALID, .MIC_MODE, .MIC_AMP_EN,
  .MIC_AMP_MUTE, .MIC_GAIN, .IN_AMP_EN, .IN_AMP_MUTE, .ADC_RATE, .MOD_CLK_44K1);
